// file: verilog/adc_cfg_pkg.sv
// Constants, field layouts, reset values and state codes for the converter configuration block.
// Assumes a 40 MHz system clock and a serial host that writes 24-bit frames; shorter frames are dropped.
package adc_cfg_pkg;

   // ----------------------------------------------------------------
   // Serial frame layout
   // ----------------------------------------------------------------
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 16;
   localparam int FRAME_W = ADDR_W + DATA_W;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
   localparam logic [7:0] ADDR_MODE_DIV   = 8'h31;
   localparam logic [7:0] ADDR_XBAR_12    = 8'h3A;
   localparam logic [7:0] ADDR_XBAR_34    = 8'h3B;
   localparam logic [7:0] ADDR_FS_TRIM    = 8'h55;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int SOFT_RESET_BIT = 0;
   localparam int MODE_LSB       = 0;
   localparam int MODE_W         = 3;
   localparam int DIV_LSB        = 8;
   localparam int DIV_W          = 2;
   localparam int SRC_LO_LSB     = 0;
   localparam int SRC_HI_LSB     = 8;
   localparam int SRC_W          = 5;
   localparam int TRIM_LSB       = 0;
   localparam int TRIM_W         = 6;

   // ----------------------------------------------------------------
   // Channel modes, divider codes and derived values
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SINGLE = 3'h1,
      MODE_DUAL   = 3'h2,
      MODE_QUAD   = 3'h4
   } channel_mode_t;

   localparam logic [1:0] DIV_BY_1 = 2'h0;
   localparam logic [1:0] DIV_BY_2 = 2'h1;
   localparam logic [1:0] DIV_BY_4 = 2'h2;
   localparam logic [1:0] DIV_BY_8 = 2'h3;

   localparam logic [3:0] BRANCHES_QUAD   = 4'h2;
   localparam logic [3:0] BRANCHES_DUAL   = 4'h4;
   localparam logic [3:0] BRANCHES_SINGLE = 4'h8;

   // Terminal counts of the sample clock divider, one per divider code.
   localparam logic [2:0] DIV_LIMIT_1 = 3'h0;
   localparam logic [2:0] DIV_LIMIT_2 = 3'h1;
   localparam logic [2:0] DIV_LIMIT_4 = 3'h3;
   localparam logic [2:0] DIV_LIMIT_8 = 3'h7;

   // Channel index of each unit, two bits per unit, unit one lowest.
   localparam logic [7:0] MAP_SINGLE = 8'h00;
   localparam logic [7:0] MAP_DUAL   = 8'h50;
   localparam logic [7:0] MAP_QUAD   = 8'hE4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_RESET     = MODE_QUAD;
   localparam logic [1:0] DIV_RESET      = DIV_BY_1;
   localparam logic [4:0] SRC_UNIT1_RESET = 5'h02;
   localparam logic [4:0] SRC_UNIT2_RESET = 5'h04;
   localparam logic [4:0] SRC_UNIT3_RESET = 5'h08;
   localparam logic [4:0] SRC_UNIT4_RESET = 5'h10;
   localparam logic [5:0] TRIM_RESET     = 6'h00;

   // ----------------------------------------------------------------
   // Serial receiver states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      RX_IDLE  = 3'h1,
      RX_SHIFT = 3'h2,
      RX_HOLD  = 3'h4
   } rx_state_t;

endpackage

// file: verilog/serial_write_receiver.sv
// Serial write receiver: turns 24-bit host frames into one-cycle register writes.
// Assumes the host serial clock is slower than an eighth of clk_sys.
`timescale 1ns/1ps
module serial_write_receiver
   import adc_cfg_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          resetn,
   // Serial pins
   input  wire logic          ser_clk,
   input  wire logic          ser_data,
   input  wire logic          ser_sel_n,
   // Write strobe and data
   output logic               wr_strobe,
   output logic [AW-1:0]      wr_addr,
   output logic [DW-1:0]      wr_data
);

   if (AW != ADDR_W || DW != DATA_W) begin : g_bad_width
      $error("serial_write_receiver: frame width does not match the package");
   end

   localparam int CW = $clog2(AW + DW + 1);
   localparam logic [CW-1:0] FRAME_BITS = CW'(AW + DW);

   typedef struct packed {
      logic [2:0]        s1;
      logic [2:0]        s2;
      logic [2:0]        s3;
      logic [2:0]        filt;
      rx_state_t         state;
      logic [CW-1:0]     count;
      logic [AW+DW-1:0]  shift;
      logic              strobe;
      logic [AW-1:0]     addr;
      logic [DW-1:0]     data;
   } rx_t;

   rx_t r_reg;
   rx_t r_next;

   // Bit 0 serial clock, bit 1 data, bit 2 select.
   always_comb begin
      r_next        = r_reg;
      r_next.strobe = 1'b0;
      r_next.s1     = {ser_sel_n, ser_data, ser_clk};
      r_next.s2     = r_reg.s1;
      r_next.s3     = r_reg.s2;
      for (int i = 0; i < 3; i++) begin
         if (r_reg.s2[i] == r_reg.s3[i]) begin
            r_next.filt[i] = r_reg.s3[i];
         end
      end
      case (r_reg.state)
         RX_IDLE: begin
            r_next.count = '0;
            if (!r_reg.filt[2]) begin
               r_next.state = RX_SHIFT;
            end
         end
         RX_SHIFT: begin
            if (r_reg.filt[2]) begin
               r_next.state = RX_IDLE;
            end else if (r_next.filt[0] && !r_reg.filt[0]) begin
               r_next.shift = {r_reg.shift[AW+DW-2:0], r_next.filt[1]};
               r_next.count = r_reg.count + CW'(1);
               if (r_reg.count == FRAME_BITS - CW'(1)) begin
                  r_next.strobe = 1'b1;
                  r_next.addr   = r_next.shift[AW+DW-1:DW];
                  r_next.data   = r_next.shift[DW-1:0];
                  r_next.state  = RX_HOLD;
               end
            end
         end
         RX_HOLD: begin
            if (r_reg.filt[2]) begin
               r_next.state = RX_IDLE;
            end
         end
         default: r_next.state = RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         r_reg       <= '0;
         r_reg.s1    <= 3'h4;
         r_reg.s2    <= 3'h4;
         r_reg.s3    <= 3'h4;
         r_reg.filt  <= 3'h4;
         r_reg.state <= RX_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign wr_strobe = r_reg.strobe;
   assign wr_addr   = r_reg.addr;
   assign wr_data   = r_reg.data;

endmodule

// file: verilog/adc_cfg_regs.sv
// Configuration registers for mode, clock divider, input crossbar and full-scale trim.
// Assumes a serial host writing 24-bit frames and a power-down pin from the pad ring.
`timescale 1ns/1ps
module adc_cfg_regs
   import adc_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   // Serial control pins
   input  wire logic       ser_clk,
   input  wire logic       ser_data,
   input  wire logic       ser_sel_n,
   // Power-down pin
   input  wire logic       power_down,
   // Mode and clocking
   output logic [2:0]      channel_mode,
   output logic [1:0]      clk_div_code,
   output logic            sample_tick,
   output logic [3:0]      branches_per_channel,
   output logic [7:0]      unit_channel_map,
   output logic            mode_change_pending,
   output logic            soft_reset_pulse,
   // Crossbar selects, one-hot over the four analog input pairs, all zero when the source code routed to the unit is invalid
   output logic [3:0]      crossbar_source_unit1,
   output logic [3:0]      crossbar_source_unit2,
   output logic [3:0]      crossbar_source_unit3,
   output logic [3:0]      crossbar_source_unit4,
   output logic            crossbar_code_error,
   // Full-scale trim
   output logic [5:0]      full_scale_trim
);

   // ----------------------------------------------------------------
   // Serial write receiver
   // ----------------------------------------------------------------
   logic              wr_strobe;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;

   serial_write_receiver #(
      .AW (ADDR_W),
      .DW (DATA_W)
   ) u_rx (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .ser_clk   (ser_clk),
      .ser_data  (ser_data),
      .ser_sel_n (ser_sel_n),
      .wr_strobe (wr_strobe),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]            mode;
      logic [1:0]            div;
      logic [3:0][SRC_W-1:0] src;
      logic [TRIM_W-1:0]     trim;
      logic                  srst;
      logic [2:0]            div_cnt;
      logic                  tick;
      logic [3:0]            branches;
      logic [7:0]            chan_map;
      logic [3:0][3:0]       eff_src;
      logic                  code_err;
      logic                  pending;
      logic                  pd_s1;
      logic                  pd_s2;
      logic                  pd_s3;
      logic                  pd_filt;
   } cfg_t;

   cfg_t c_reg;
   cfg_t c_next;

   // Checks a five-bit source code: one bit set in 4..1 and bit 0 clear.
   function automatic logic src_valid(input logic [SRC_W-1:0] code);
      logic ok;
      ok = 1'b0;
      if (code[0] == 1'b0 && $countones(code[SRC_W-1:1]) == 1) begin
         ok = 1'b1;
      end
      return ok;
   endfunction

   always_comb begin
      logic [2:0]      limit;
      logic [3:0][3:0] hot;
      limit  = DIV_LIMIT_1;
      hot    = '0;
      c_next = c_reg;
      c_next.srst = 1'b0;

      // Power-down pin filter: follows the pin once second and third stage agree.
      c_next.pd_s1 = power_down;
      c_next.pd_s2 = c_reg.pd_s1;
      c_next.pd_s3 = c_reg.pd_s2;
      if (c_reg.pd_s2 == c_reg.pd_s3) begin
         c_next.pd_filt = c_reg.pd_s3;
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      // No power-down gating
      if (wr_strobe) begin
         if (wr_addr == ADDR_SOFT_RESET) begin
            c_next.srst = wr_data[SOFT_RESET_BIT];
         end else if (wr_addr == ADDR_MODE_DIV) begin
            c_next.mode    = wr_data[MODE_LSB +: MODE_W];
            c_next.div     = wr_data[DIV_LSB +: DIV_W];
            c_next.pending = 1'b1;
         end else if (wr_addr == ADDR_XBAR_12) begin
            c_next.src[0] = wr_data[SRC_LO_LSB +: SRC_W];
            c_next.src[1] = wr_data[SRC_HI_LSB +: SRC_W];
         end else if (wr_addr == ADDR_XBAR_34) begin
            c_next.src[2] = wr_data[SRC_LO_LSB +: SRC_W];
            c_next.src[3] = wr_data[SRC_HI_LSB +: SRC_W];
         end else if (wr_addr == ADDR_FS_TRIM) begin
            c_next.trim = wr_data[TRIM_LSB +: TRIM_W];
         end
      end

      if (c_reg.srst) begin
         c_next.mode    = MODE_RESET;
         c_next.div     = DIV_RESET;
         c_next.src[0]  = SRC_UNIT1_RESET;
         c_next.src[1]  = SRC_UNIT2_RESET;
         c_next.src[2]  = SRC_UNIT3_RESET;
         c_next.src[3]  = SRC_UNIT4_RESET;
         c_next.trim    = TRIM_RESET;
         c_next.pending = 1'b1;
      end

      if (c_reg.pd_filt && !(wr_strobe && wr_addr == ADDR_MODE_DIV) && !c_reg.srst) begin
         c_next.pending = 1'b0;
      end

      // ----------------------------------------------------------------
      // Sample clock divider
      // ----------------------------------------------------------------
      // Divide by 1, 2, 4, 8
      case (c_reg.div)
         DIV_BY_1: limit = DIV_LIMIT_1;
         DIV_BY_2: limit = DIV_LIMIT_2;
         DIV_BY_4: limit = DIV_LIMIT_4;
         default:  limit = DIV_LIMIT_8;
      endcase
      if (c_reg.div_cnt >= limit) begin
         c_next.div_cnt = 3'h0;
         c_next.tick    = 1'b1;
      end else begin
         c_next.div_cnt = c_reg.div_cnt + 3'h1;
         c_next.tick    = 1'b0;
      end

      // ----------------------------------------------------------------
      // Mode decode and crossbar routing
      // ----------------------------------------------------------------
      c_next.code_err = 1'b0;
      for (int u = 0; u < 4; u++) begin
         if (!src_valid(c_next.src[u])) begin
            c_next.code_err = 1'b1;
         end else begin
            hot[u] = c_next.src[u][SRC_W-1:1];
         end
      end
      case (c_next.mode)
         MODE_SINGLE: begin
            c_next.branches = BRANCHES_SINGLE;
            c_next.chan_map = MAP_SINGLE;
            for (int u = 0; u < 4; u++) begin
               c_next.eff_src[u] = hot[0];
            end
         end
         MODE_DUAL: begin
            c_next.branches = BRANCHES_DUAL;
            c_next.chan_map = MAP_DUAL;
            for (int u = 0; u < 4; u++) begin
               c_next.eff_src[u] = (u < 2) ? hot[0] : hot[2];
            end
         end
         default: begin
            c_next.branches = BRANCHES_QUAD;
            c_next.chan_map = MAP_QUAD;
            for (int u = 0; u < 4; u++) begin
               c_next.eff_src[u] = hot[u];
            end
         end
      endcase
      if (c_next.mode != MODE_SINGLE && c_next.mode != MODE_DUAL
          && c_next.mode != MODE_QUAD) begin
         c_next.code_err = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         c_reg          <= '0;
         c_reg.mode     <= MODE_RESET;
         c_reg.div      <= DIV_RESET;
         c_reg.src[0]   <= SRC_UNIT1_RESET;
         c_reg.src[1]   <= SRC_UNIT2_RESET;
         c_reg.src[2]   <= SRC_UNIT3_RESET;
         c_reg.src[3]   <= SRC_UNIT4_RESET;
         c_reg.trim     <= TRIM_RESET;
         c_reg.branches <= BRANCHES_QUAD;
         c_reg.chan_map <= MAP_QUAD;
         c_reg.eff_src  <= {SRC_UNIT4_RESET[SRC_W-1:1], SRC_UNIT3_RESET[SRC_W-1:1],
                            SRC_UNIT2_RESET[SRC_W-1:1], SRC_UNIT1_RESET[SRC_W-1:1]};
      end else begin
         c_reg <= c_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign channel_mode          = c_reg.mode;
   assign clk_div_code          = c_reg.div;
   assign sample_tick           = c_reg.tick;
   assign branches_per_channel  = c_reg.branches;
   assign unit_channel_map      = c_reg.chan_map;
   assign mode_change_pending   = c_reg.pending;
   assign soft_reset_pulse      = c_reg.srst;
   assign crossbar_source_unit1 = c_reg.eff_src[0];
   assign crossbar_source_unit2 = c_reg.eff_src[1];
   assign crossbar_source_unit3 = c_reg.eff_src[2];
   assign crossbar_source_unit4 = c_reg.eff_src[3];
   assign crossbar_code_error   = c_reg.code_err;
   assign full_scale_trim       = c_reg.trim;

endmodule

// file: verification/adc_cfg_regs_chk.sv
// Assertion checker for the converter configuration register block.
// Assumes it is bound to adc_cfg_regs and sees only that module's ports.
`timescale 1ns/1ps
module adc_cfg_regs_chk
   import adc_cfg_pkg::*;
(
   // Clock, reset and pins
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic       ser_clk,
   input wire logic       ser_data,
   input wire logic       ser_sel_n,
   input wire logic       power_down,
   // Mode and clocking
   input wire logic [2:0] channel_mode,
   input wire logic [1:0] clk_div_code,
   input wire logic       sample_tick,
   input wire logic [3:0] branches_per_channel,
   input wire logic [7:0] unit_channel_map,
   input wire logic       mode_change_pending,
   input wire logic       soft_reset_pulse,
   // Crossbar and trim
   input wire logic [3:0] crossbar_source_unit1,
   input wire logic [3:0] crossbar_source_unit2,
   input wire logic [3:0] crossbar_source_unit3,
   input wire logic [3:0] crossbar_source_unit4,
   input wire logic       crossbar_code_error,
   input wire logic [5:0] full_scale_trim
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------
   sequence defaults_seen;
      channel_mode == MODE_RESET && clk_div_code == DIV_RESET
         && full_scale_trim == TRIM_RESET && mode_change_pending;
   endsequence
   sequence pd_held;
      power_down [*8];
   endsequence

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_SRST_DEFAULTS: assert property (soft_reset_pulse |=> defaults_seen)
      else $error("soft reset did not restore defaults");
   AST_SRST_SINGLE: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse longer than one cycle");
   AST_MODE_BRANCHES: assert property ($stable(channel_mode) |-> branches_per_channel ==
      (channel_mode == MODE_SINGLE ? 4'h8 : (channel_mode == MODE_DUAL ? 4'h4 : 4'h2)))
      else $error("branch count does not follow mode");
   AST_MODE_MAP: assert property ($stable(channel_mode) |-> unit_channel_map ==
      (channel_mode == MODE_SINGLE ? 8'h00 : (channel_mode == MODE_DUAL ? 8'h50 : 8'hE4)))
      else $error("unit map does not follow mode");
   AST_XBAR_ONEHOT: assert property (!crossbar_code_error |-> $onehot(crossbar_source_unit1)
      && $onehot(crossbar_source_unit2) && $onehot(crossbar_source_unit3)
      && $onehot(crossbar_source_unit4))
      else $error("crossbar select not one-hot without error");
   AST_SINGLE_SHARE: assert property (channel_mode == MODE_SINGLE && $stable(channel_mode)
      && $stable(crossbar_source_unit1) |-> crossbar_source_unit2 == crossbar_source_unit1
      && crossbar_source_unit3 == crossbar_source_unit1
      && crossbar_source_unit4 == crossbar_source_unit1)
      else $error("single mode units do not share one input");
   AST_DUAL_SHARE: assert property (channel_mode == MODE_DUAL && $stable(channel_mode)
      && $stable(crossbar_source_unit1) && $stable(crossbar_source_unit3)
      |-> crossbar_source_unit2 == crossbar_source_unit1
      && crossbar_source_unit4 == crossbar_source_unit3)
      else $error("dual mode pairs do not share inputs");
   AST_DIV2_GAP: assert property (sample_tick && clk_div_code == DIV_BY_2
      && $stable(clk_div_code) |=> !sample_tick || clk_div_code != DIV_BY_2)
      else $error("divide by two ticked twice in a row");
   AST_PD_CLEARS: assert property (pd_held |-> !mode_change_pending
      || $rose(mode_change_pending))
      else $error("power down did not clear pending mode change");
   AST_MODE_MARKS: assert property ($changed(channel_mode) || $changed(clk_div_code)
      |-> mode_change_pending)
      else $error("mode or divider change not marked pending");
endmodule

bind adc_cfg_regs adc_cfg_regs_chk u_adc_cfg_regs_chk (
   .clk_sys(clk_sys), .resetn(resetn), .ser_clk(ser_clk), .ser_data(ser_data),
   .ser_sel_n(ser_sel_n), .power_down(power_down), .channel_mode(channel_mode),
   .clk_div_code(clk_div_code), .sample_tick(sample_tick),
   .branches_per_channel(branches_per_channel), .unit_channel_map(unit_channel_map),
   .mode_change_pending(mode_change_pending), .soft_reset_pulse(soft_reset_pulse),
   .crossbar_source_unit1(crossbar_source_unit1), .crossbar_source_unit2(crossbar_source_unit2),
   .crossbar_source_unit3(crossbar_source_unit3), .crossbar_source_unit4(crossbar_source_unit4),
   .crossbar_code_error(crossbar_code_error), .full_scale_trim(full_scale_trim)
);

// file: verification/serial_host_model.sv
// Serial host model that writes 24-bit address and data frames, MSB first.
// Assumes a free-running clk_sys; the serial clock idles low between frames.
`timescale 1ns/1ps
module serial_host_model (
   // System clock
   input  wire logic clk_sys,
   // Serial pins
   output logic      ser_clk,
   output logic      ser_data,
   output logic      ser_sel_n
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_sel_n = 1'b1;
   end

   // Eight system cycles per half period leave margin on every setup and hold.
   task automatic half_period();
      repeat (8) @(negedge clk_sys);
   endtask

   // Fewer than 24 bits makes a truncated frame that the block must drop.
   task automatic write_frame(input logic [7:0] addr, input logic [15:0] data, input int nbits);
      logic [23:0] frame;
      frame = {addr, data};
      @(negedge clk_sys);
      ser_sel_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         ser_data = frame[23-i];
         half_period();
         ser_clk = 1'b1;
         half_period();
         ser_clk = 1'b0;
      end
      half_period();
      ser_data = ~ser_data;
      ser_sel_n = 1'b1;
      half_period();
   endtask
endmodule

// file: verification/testbench.sv
// Self-checking testbench for the converter configuration register block.
// Assumes a 40 MHz clk_sys and the serial host model on the control pins.
`timescale 1ns/1ps
module testbench
   import adc_cfg_pkg::*;
;
   logic       clk_sys = 1'b0;
   logic       resetn;
   logic       power_down;
   logic       ser_clk, ser_data, ser_sel_n, sample_tick, mode_change_pending;
   logic       soft_reset_pulse, crossbar_code_error;
   logic [2:0] channel_mode;
   logic [1:0] clk_div_code;
   logic [3:0] branches_per_channel, src1, src2, src3, src4;
   logic [7:0] unit_channel_map;
   logic [5:0] full_scale_trim;
   int         fails = 0;
   int         tests_run = 0;
   int         cycles = 0;
   int         srst_count = 0;

   always #12.5 clk_sys = ~clk_sys;

   serial_host_model u_serial_host_model (.clk_sys(clk_sys), .ser_clk(ser_clk),
      .ser_data(ser_data), .ser_sel_n(ser_sel_n));

   adc_cfg_regs u_adc_cfg_regs (.clk_sys(clk_sys), .resetn(resetn), .ser_clk(ser_clk),
      .ser_data(ser_data), .ser_sel_n(ser_sel_n), .power_down(power_down),
      .channel_mode(channel_mode), .clk_div_code(clk_div_code), .sample_tick(sample_tick),
      .branches_per_channel(branches_per_channel), .unit_channel_map(unit_channel_map),
      .mode_change_pending(mode_change_pending), .soft_reset_pulse(soft_reset_pulse),
      .crossbar_source_unit1(src1), .crossbar_source_unit2(src2),
      .crossbar_source_unit3(src3), .crossbar_source_unit4(src4),
      .crossbar_code_error(crossbar_code_error), .full_scale_trim(full_scale_trim));

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Soft reset pulses are counted and a hung run is cut short.
   always @(posedge clk_sys) begin
      cycles++;
      if (soft_reset_pulse === 1'b1) srst_count++;
      if (cycles == 20000) begin
         fails++;
         final_report();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [15:0] data);
      u_serial_host_model.write_frame(addr, data, 24);
   endtask

   task automatic pd_cycle();
      power_down = 1'b1;
      repeat (12) @(negedge clk_sys);
      power_down = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask

   task automatic t_defaults();
      chk("mode", 16'(MODE_QUAD), 16'(channel_mode));
      chk("div", 16'(DIV_BY_1), 16'(clk_div_code));
      chk("branches", 16'h0002, 16'(branches_per_channel));
      chk("map", 16'h00E4, 16'(unit_channel_map));
      chk("srcs", 16'h8421, {src4, src3, src2, src1});
   endtask

   task automatic t_xbar();
      wr(ADDR_XBAR_12, 16'h0003);
      chk("code_error", 16'h0001, 16'(crossbar_code_error));
      chk("src1 bad", 16'h0000, 16'(src1));
      wr(ADDR_XBAR_12, 16'h0410);
      chk("srcs12", 16'h0028, {8'h00, src2, src1});
      chk("code_error", 16'h0000, 16'(crossbar_code_error));
      power_down = 1'b1;
      wr(ADDR_XBAR_34, 16'h0802);
      power_down = 1'b0;
      chk("srcs34", 16'h0041, {8'h00, src4, src3});
   endtask

   task automatic t_modes();
      logic [2:0] md [4];
      logic [1:0] dv [4];
      int         ticks;
      md = '{MODE_SINGLE, MODE_DUAL, MODE_QUAD, MODE_QUAD};
      dv = '{DIV_BY_1, DIV_BY_2, DIV_BY_4, DIV_BY_8};
      for (int i = 0; i < 4; i++) begin
         // one mode bit, unused bits zero, divider tracks count
         wr(ADDR_MODE_DIV, {6'h00, dv[i], 5'h00, md[i]});
         chk("mode", 16'(md[i]), 16'(channel_mode));
         chk("div", 16'(dv[i]), 16'(clk_div_code));
         chk("pending", 16'h0001, 16'(mode_change_pending));
         chk("branches", (md[i] == 3'h1) ? 16'h8 : (md[i] == 3'h2) ? 16'h4 : 16'h2,
            16'(branches_per_channel));
         chk("map", (md[i] == 3'h1) ? 16'h00 : (md[i] == 3'h2) ? 16'h50 : 16'hE4,
            16'(unit_channel_map));
         chk("srcs", (md[i] == 3'h1) ? 16'h8888 : (md[i] == 3'h2) ? 16'h1188 : 16'h4128,
            {src4, src3, src2, src1});
         // power down after the mode change
         pd_cycle();
         chk("pending", 16'h0000, 16'(mode_change_pending));
         ticks = 0;
         repeat (64) begin
            @(negedge clk_sys);
            if (sample_tick === 1'b1) ticks++;
         end
         chk("ticks", 16'(64 >> dv[i]), 16'(ticks));
      end
   endtask

   task automatic t_trim();
      wr(ADDR_FS_TRIM, 16'h003F);
      chk("trim", 16'h003F, 16'(full_scale_trim));
      u_serial_host_model.write_frame(ADDR_FS_TRIM, 16'h0015, 23);
      chk("trim short", 16'h003F, 16'(full_scale_trim));
      wr(8'h7F, 16'h0015);
      chk("trim unmapped", 16'h003F, 16'(full_scale_trim));
      wr(ADDR_FS_TRIM, 16'h0015);
      chk("trim", 16'h0015, 16'(full_scale_trim));
   endtask

   task automatic t_soft_reset();
      srst_count = 0;
      wr(ADDR_SOFT_RESET, 16'h0001);
      chk("srst pulses", 16'h0001, 16'(srst_count));
      chk("trim", 16'h0000, 16'(full_scale_trim));
      chk("pending", 16'h0001, 16'(mode_change_pending));
      t_defaults();
      pd_cycle();
   endtask

   initial begin
      resetn = 1'b0;
      power_down = 1'b0;
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (4) @(negedge clk_sys);
      t_defaults();
      t_xbar();
      t_modes();
      t_trim();
      t_soft_reset();
      final_report();
   end
endmodule
